// ===== design/qst_pkg.sv
// constants and types for the four-channel serializer transmit path
package qst_pkg;

  // channel and character geometry
  localparam int NUM_CH = 4;
  localparam int CHAR_W = 10;
  localparam int BUS_W = 8;
  localparam logic [3:0] CHAR_LAST = 4'h9;
  localparam logic [9:0] INVALID_CHAR = 10'h278;

  // phase-align buffer
  localparam int BUF_DEPTH = 4;
  localparam int BUF_PTR_W = 3;
  localparam logic [2:0] BUF_FULL = 3'h4;
  localparam logic [2:0] BUF_INIT_FILL = 3'h2;

  // self-test generator
  localparam int LFSR_W = 9;
  localparam logic [8:0] LFSR_SEED = 9'h1FF;

  // wishbone register map, byte addresses
  localparam int ADR_W = 8;
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;

  // control register fields
  localparam int CTRL_ICS_LSB = 0;
  localparam int CTRL_PAR_LSB = 2;
  localparam int CTRL_SPD_LSB = 4;
  localparam int CTRL_HALF_BIT = 8;
  localparam int CTRL_LOOP_LSB = 12;
  localparam logic [1:0] TRI_RESET = 2'h0;
  localparam logic [3:0] LOOP_RESET = 4'h0;

  // status register fields
  localparam int STAT_ERR_LSB = 0;
  localparam int STAT_BIST_LSB = 4;
  localparam int STAT_OE_LSB = 8;
  localparam int STAT_BADMODE_BIT = 12;
  localparam int STAT_ARMED_BIT = 13;

  typedef enum logic [1:0] {QST_LOW, QST_MID, QST_HIGH} qst_tri_t;
  typedef enum logic [1:0] {INIT_RUN, INIT_SEEN1, INIT_ARMED} qst_init_t;

endpackage : qst_pkg

// ===== design/qst_tx_path.sv
// transmit path of a four-channel serializer with wishbone control registers
//
// Contract
// - select LOW samples inputs on reference clock; HIGH on shared channel-A clock.
// - select middle samples each channel on its own transmit clock.
// - input register takes ten character bits per input clock, bit 5 is code i.
// - characters leave the serializer least significant bit first.
// - reference clock at full rate bypasses the phase-align buffers.
// - any other clock or half-rate mode routes data through phase-align buffers.
// - init input low over two reference edges arms; rising records clock phase.
// - buffer init input is synchronized before use.
// - aligned buffer absorbs half a character of drift either way; code allows two characters either way.
// - buffer overrun or underrun sets a sticky error until reinitialized.
// - while error stands the channel sends the invalid character continuously; code sends the self-test character instead while self-test is enabled.
// - odd parity over ten bits and parity bit; checked unless control is LOW.
// - failing character is replaced by the invalid character.
// - self-test turns a channel register into a 511-state LFSR generator.
// - self-test latch transparent while open; LOW bus bit enables; holds when closed.
// - device reset presets self-test latch to disabled.
// - parallel inputs are ignored on a channel running self-test.
// - odd bus bits map self-test D..A, even bits map outputs D..A.
// - driver latch transparent while open; HIGH enables, LOW powers down channel.
// - device reset clears output-enable latch, all drivers off.
// - loopback forces enabled drivers to constant logic one.
// - bit clock is reference times 10 or 20; character clock drives the path.
// - device reset sampled on reference edge clears state machines and latches; code applies it on every clk edge.
`timescale 1ns/1ps
`default_nettype none

module qst_tx_path (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [qst_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic device_reset_n_i,
  input wire logic shared_char_clock_i,
  input wire logic [qst_pkg::NUM_CH-1:0] channel_char_clock_i,
  input wire logic [qst_pkg::NUM_CH-1:0][qst_pkg::CHAR_W-1:0] char_in_i,
  input wire logic [qst_pkg::NUM_CH-1:0] char_parity_in_i,
  input wire logic align_buffer_init_n_i,
  input wire logic selftest_latch_open_i,
  input wire logic driver_latch_open_i,
  input wire logic [qst_pkg::BUS_W-1:0] shared_enable_bus_i,
  output logic [qst_pkg::NUM_CH-1:0] serial_out_o,
  output logic [qst_pkg::NUM_CH-1:0] serial_drive_en_o,
  output logic [qst_pkg::NUM_CH-1:0] align_error_out_o
);
  import qst_pkg::*;

  function automatic qst_tri_t tri_decode(input logic [1:0] code);
    case (code)
      2'h0: tri_decode = QST_LOW;
      2'h3: tri_decode = QST_HIGH;
      default: tri_decode = QST_MID;
    endcase
  endfunction : tri_decode

  function automatic logic parity_ok(input logic [CHAR_W-1:0] c, input logic p);
    parity_ok = ^{c, p};
  endfunction : parity_ok

  function automatic logic [LFSR_W-1:0] lfsr_step(input logic [LFSR_W-1:0] s);
    // x^9 + x^5 + 1, maximal length 511
    lfsr_step = {s[LFSR_W-2:0], s[8] ^ s[4]};
  endfunction : lfsr_step

  // control register state
  logic [1:0] ics_reg;
  logic [1:0] par_reg;
  logic [1:0] spd_reg;
  logic half_rate_reg;
  logic [NUM_CH-1:0] loop_reg;

  // device reset folds in the pin, applied on every clk edge
  logic dev_rst;
  assign dev_rst = rst_i | ~device_reset_n_i;

  qst_tri_t ics;
  qst_tri_t par_mode;
  logic bypass;
  logic bad_mode;
  assign ics = tri_decode(ics_reg);
  assign par_mode = tri_decode(par_reg);
  assign bypass = (ics == QST_LOW) && !half_rate_reg;
  assign bad_mode = (ics != QST_LOW) && half_rate_reg;

  // character-rate enable; each clk stands for one bit time
  logic [3:0] char_cnt;
  logic half_phase;
  logic char_en;
  logic ref_tick;
  assign char_en = (char_cnt == CHAR_LAST);
  // half-rate reference edge comes every second character (x20)
  assign ref_tick = char_en & (~half_rate_reg | half_phase);

  always_ff @(posedge clk_i) begin
    if (dev_rst) begin
      char_cnt <= 4'h0;
      half_phase <= 1'b0;
    end else if (char_en) begin
      char_cnt <= 4'h0;
      half_phase <= ~half_phase;
    end else begin
      char_cnt <= char_cnt + 4'h1;
    end
  end

  // wishbone slave: ack one cycle after the request, unmapped reads zero
  logic wb_req;
  logic [31:0] status_word;
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ics_reg <= TRI_RESET;
      par_reg <= TRI_RESET;
      spd_reg <= TRI_RESET;
      half_rate_reg <= 1'b0;
      loop_reg <= LOOP_RESET;
    end else if (wb_req && wb_we_i && wb_adr_i == ADR_CTRL) begin
      if (wb_sel_i[0]) begin
        ics_reg <= wb_dat_i[CTRL_ICS_LSB +: 2];
        par_reg <= wb_dat_i[CTRL_PAR_LSB +: 2];
        spd_reg <= wb_dat_i[CTRL_SPD_LSB +: 2];
      end
      if (wb_sel_i[1]) begin
        half_rate_reg <= wb_dat_i[CTRL_HALF_BIT];
        loop_reg <= wb_dat_i[CTRL_LOOP_LSB +: NUM_CH];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req && !wb_we_i) begin
      case (wb_adr_i)
        ADR_CTRL: begin
          wb_dat_o <= {16'h0000, loop_reg, 3'h0, half_rate_reg, 2'h0, spd_reg,
                       par_reg, ics_reg};
        end
        ADR_STATUS: wb_dat_o <= status_word;
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // enable latches sharing one bus; transparent while open, hold when closed
  logic [NUM_CH-1:0] bist_en;
  logic [NUM_CH-1:0] oe_en;

  always_ff @(posedge clk_i) begin
    if (dev_rst) begin
      bist_en <= '0;
    end else if (selftest_latch_open_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
        bist_en[c] <= ~shared_enable_bus_i[2*c+1];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (dev_rst) begin
      oe_en <= '0;
    end else if (driver_latch_open_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
        oe_en[c] <= shared_enable_bus_i[2*c];
      end
    end
  end

  // buffer init pin is asynchronous: two-flop synchroniser first
  logic init_meta;
  logic init_sync;
  qst_init_t init_state;
  logic init_do;

  always_ff @(posedge clk_i) begin
    if (dev_rst) begin
      init_meta <= 1'b1;
      init_sync <= 1'b1;
    end else begin
      init_meta <= align_buffer_init_n_i;
      init_sync <= init_meta;
    end
  end

  assign init_do = (init_state == INIT_ARMED) && init_sync;

  always_ff @(posedge clk_i) begin
    if (dev_rst) begin
      init_state <= INIT_RUN;
    end else begin
      case (init_state)
        INIT_RUN: begin
          if (ref_tick && !init_sync) begin
            init_state <= INIT_SEEN1;
          end
        end
        INIT_SEEN1: begin
          if (ref_tick) begin
            init_state <= init_sync ? INIT_RUN : INIT_ARMED;
          end
        end
        INIT_ARMED: begin
          if (init_sync) begin
            init_state <= INIT_RUN;
          end
        end
        default: init_state <= INIT_RUN;
      endcase
    end
  end

  // input capture strobes, one per channel
  logic shared_clk_q;
  logic [NUM_CH-1:0] ch_clk_q;
  logic [NUM_CH-1:0] cap_stb;

  always_ff @(posedge clk_i) begin
    if (dev_rst) begin
      shared_clk_q <= 1'b0;
      ch_clk_q <= '0;
    end else begin
      shared_clk_q <= shared_char_clock_i;
      ch_clk_q <= channel_char_clock_i;
    end
  end

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      case (ics)
        QST_LOW: cap_stb[c] = char_en;
        QST_HIGH: cap_stb[c] = shared_char_clock_i & ~shared_clk_q;
        QST_MID: cap_stb[c] = channel_char_clock_i[c] & ~ch_clk_q[c];
        default: cap_stb[c] = char_en;
      endcase
    end
  end

  logic [NUM_CH-1:0][CHAR_W-1:0] in_char;
  logic [NUM_CH-1:0] in_par;
  logic [NUM_CH-1:0] wr_stb;

  always_ff @(posedge clk_i) begin
    if (dev_rst) begin
      in_char <= '0;
      in_par <= '0;
      wr_stb <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        wr_stb[c] <= cap_stb[c] & ~bypass;
        if (cap_stb[c]) begin
          in_char[c] <= char_in_i[c];
          in_par[c] <= char_parity_in_i[c];
        end
      end
    end
  end

  // phase-align buffers: centred fill gives two characters slack each way
  logic [CHAR_W:0] buf_mem [NUM_CH][BUF_DEPTH];
  logic [NUM_CH-1:0][BUF_PTR_W-1:0] wr_ptr;
  logic [NUM_CH-1:0][BUF_PTR_W-1:0] rd_ptr;
  logic [NUM_CH-1:0] align_err;
  logic [NUM_CH-1:0] rd_stb;
  logic [NUM_CH-1:0] overrun;
  logic [NUM_CH-1:0] underrun;

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      logic [BUF_PTR_W-1:0] fill;
      fill = wr_ptr[c] - rd_ptr[c];
      rd_stb[c] = char_en & ~bypass;
      overrun[c] = wr_stb[c] & ~rd_stb[c] & (fill == BUF_FULL);
      underrun[c] = rd_stb[c] & ~wr_stb[c] & (fill == 3'h0);
    end
  end

  always_ff @(posedge clk_i) begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (wr_stb[c] && !overrun[c]) begin
        buf_mem[c][wr_ptr[c][1:0]] <= {in_par[c], in_char[c]};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (dev_rst) begin
      wr_ptr <= {NUM_CH{BUF_INIT_FILL}};
      rd_ptr <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (init_do) begin
          // current input phase becomes the centre of the buffer
          wr_ptr[c] <= BUF_INIT_FILL;
          rd_ptr[c] <= 3'h0;
        end else begin
          if (wr_stb[c] && !overrun[c]) begin
            wr_ptr[c] <= wr_ptr[c] + 3'h1;
          end
          if (rd_stb[c] && !underrun[c]) begin
            rd_ptr[c] <= rd_ptr[c] + 3'h1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (dev_rst) begin
      align_err <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        // a slip in the same cycle as reinit still sets the error
        align_err[c] <= (align_err[c] & ~init_do) | overrun[c] | underrun[c];
      end
    end
  end

  // self-test generators, advance once per character while the channel driver is enabled
  logic [NUM_CH-1:0][LFSR_W-1:0] lfsr;

  always_ff @(posedge clk_i) begin
    if (dev_rst) begin
      lfsr <= {NUM_CH{LFSR_SEED}};
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (!bist_en[c]) begin
          lfsr[c] <= LFSR_SEED;
        end else if (char_en && oe_en[c]) begin
          lfsr[c] <= lfsr_step(lfsr[c]);
        end
      end
    end
  end

  // character selection and serializer
  logic [NUM_CH-1:0][CHAR_W-1:0] shreg;
  logic [NUM_CH-1:0][CHAR_W-1:0] tx_char;

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      logic [CHAR_W:0] src;
      src = bypass ? {in_par[c], in_char[c]} : buf_mem[c][rd_ptr[c][1:0]];
      if (bist_en[c]) begin
        // bits 0 and 4 folded into the tenth bit so it still varies
        tx_char[c] = {lfsr[c][0] ^ lfsr[c][4], lfsr[c]};
      end else if (align_err[c]) begin
        tx_char[c] = INVALID_CHAR;
      end else if (par_mode != QST_LOW && !parity_ok(src[CHAR_W-1:0], src[CHAR_W])) begin
        tx_char[c] = INVALID_CHAR;
      end else begin
        tx_char[c] = src[CHAR_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (dev_rst) begin
      shreg <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (!oe_en[c]) begin
          shreg[c] <= '0;
        end else if (char_en) begin
          shreg[c] <= tx_char[c];
        end else begin
          shreg[c] <= {1'b0, shreg[c][CHAR_W-1:1]};
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (dev_rst) begin
      serial_out_o <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (!oe_en[c]) begin
          serial_out_o[c] <= 1'b0;
        end else if (|loop_reg) begin
          // keeps diagnostic patterns off the remote link
          serial_out_o[c] <= 1'b1;
        end else begin
          serial_out_o[c] <= shreg[c][0];
        end
      end
    end
  end

  assign serial_drive_en_o = oe_en;
  assign align_error_out_o = align_err;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[STAT_ERR_LSB +: NUM_CH] = align_err;
    status_word[STAT_BIST_LSB +: NUM_CH] = bist_en;
    status_word[STAT_OE_LSB +: NUM_CH] = oe_en;
    status_word[STAT_BADMODE_BIT] = bad_mode;
    status_word[STAT_ARMED_BIT] = (init_state == INIT_ARMED);
  end

endmodule : qst_tx_path

`default_nettype wire

// ===== sim/qst_tx_path_assertions.sv
// port-level checks on the transmit path
`timescale 1ns/1ps
`default_nettype none
module qst_tx_path_assertions (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic device_reset_n_i,
  input wire logic align_buffer_init_n_i,
  input wire logic driver_latch_open_i,
  input wire logic [7:0] shared_enable_bus_i,
  input wire logic [3:0] serial_out_o,
  input wire logic [3:0] serial_drive_en_o,
  input wire logic [3:0] align_error_out_o
);
  logic [2:0] hi_cnt_reg;
  wire [3:0] oe_bits = {shared_enable_bus_i[6], shared_enable_bus_i[4],
    shared_enable_bus_i[2], shared_enable_bus_i[0]};

  // init pin is resynchronised, so a reinit may land a few clocks after it rises
  always_ff @(posedge clk_i) begin
    if (rst_i || !align_buffer_init_n_i) begin
      hi_cnt_reg <= 3'h0;
    end else if (hi_cnt_reg != 3'h7) begin
      hi_cnt_reg <= hi_cnt_reg + 3'h1;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_oe_reset: assert property (!device_reset_n_i |=> serial_drive_en_o == 4'h0)
    else $error("drivers enabled after device reset");
  a_devrst_clear: assert property (!device_reset_n_i
    |=> align_error_out_o == 4'h0 && serial_out_o == 4'h0)
    else $error("state not cleared by device reset");
  a_oe_follow: assert property (driver_latch_open_i && device_reset_n_i
    |=> serial_drive_en_o == $past(oe_bits))
    else $error("enable latch did not follow bus");
  a_oe_hold: assert property (!driver_latch_open_i && device_reset_n_i
    |=> $stable(serial_drive_en_o))
    else $error("closed enable latch changed");
  a_off_quiet: assert property ((~$past(serial_drive_en_o) & ~serial_drive_en_o
    & serial_out_o) == 4'h0)
    else $error("disabled driver not at zero");
  a_err_sticky: assert property (device_reset_n_i && hi_cnt_reg == 3'h7
    |=> (align_error_out_o & $past(align_error_out_o)) == $past(align_error_out_o))
    else $error("align error dropped without reinit");

  c_err: cover property ($rose(align_error_out_o[0]));
  c_oe_all: cover property (serial_drive_en_o == 4'hF);
  c_bus: cover property (wb_ack_o && wb_cyc_i);
endmodule : qst_tx_path_assertions
`default_nettype wire

// ===== sim/qst_rx_model.sv
// remote serial receiver: deserialises each lane, first bit ends at the bottom
`timescale 1ns/1ps
`default_nettype none
module qst_rx_model (
  input wire logic clk_i,
  input wire logic [3:0] serial_i,
  output logic [3:0][9:0] word_o
);
  always_ff @(posedge clk_i) begin
    for (int c = 0; c < 4; c++) begin
      word_o[c] <= {serial_i[c], word_o[c][9:1]};
    end
  end
endmodule : qst_rx_model
`default_nettype wire

// ===== sim/tb_top.sv
// self-checking bench for the transmit path
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import qst_pkg::*;
  logic clk = 1'b0, rst = 1'b1, dev_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic shck = 1'b0, init_n = 1'b1, ste = 1'b0, oel = 1'b0;
  logic [7:0] adr = 8'h00, bus = 8'hFF;
  logic [31:0] wdat = 32'h0, rs = 32'h369A;
  logic [3:0] par = 4'h0, sel = 4'h0;
  logic [3:0][9:0] din = '0;
  int half = 5, num_errors = 0, comparisons = 0;
  wire [31:0] rdat;
  wire ack;
  wire [3:0] sout, den, aerr;
  wire [3:0][9:0] word;

  qst_tx_path i_dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .device_reset_n_i(dev_n), .shared_char_clock_i(shck), .channel_char_clock_i({4{shck}}),
    .char_in_i(din), .char_parity_in_i(par), .align_buffer_init_n_i(init_n),
    .selftest_latch_open_i(ste), .driver_latch_open_i(oel), .shared_enable_bus_i(bus),
    .serial_out_o(sout), .serial_drive_en_o(den), .align_error_out_o(aerr));
  qst_rx_model i_rx (.clk_i(clk), .serial_i(sout), .word_o(word));

  initial begin
    forever #50 clk = ~clk;
  end

  // far-side character clock; a short half period overruns the align buffer
  always begin
    repeat (half) @(posedge clk);
    shck <= ~shck;
  end

  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd

  function automatic logic [9:0] exp_char(input logic [9:0] c, input logic p,
      input logic [1:0] pc);
    return (pc != 2'h0 && (^{c, p}) !== 1'b1) ? INVALID_CHAR : c;
  endfunction : exp_char

  // n-th self-test character after enable: x^9 + x^5 + 1 from the seed
  function automatic logic [9:0] bist_char(input int n);
    logic [8:0] s;
    s = LFSR_SEED;
    repeat (n) s = {s[7:0], s[8] ^ s[4]};
    return {s[0] ^ s[4], s};
  endfunction : bist_char

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask : tk

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    int i;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hF;
    adr <= a;
    wdat <= d;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && i < 50);
    if (i >= 50) begin
      num_errors++;
      report_and_stop();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
    @(posedge clk);
  endtask : wb

  task automatic latch(input logic oe, input logic [7:0] v);
    bus <= v;
    oel <= oe;
    ste <= !oe;
    tk(2);
    oel <= 1'b0;
    ste <= 1'b0;
    tk(1);
  endtask : latch

  // low across several character ticks so two consecutive reference edges see it
  task automatic binit();
    init_n <= 1'b0;
    tk(50);
    init_n <= 1'b1;
    tk(10);
  endtask : binit

  // the stream is periodic, so scanning a span catches the aligned word
  task automatic seek(input int c, input logic [9:0] e, input int n, input logic want);
    logic hit;
    hit = 1'b0;
    repeat (n) begin
      @(posedge clk);
      if (word[c] === e) hit = 1'b1;
    end
    chk(32'(hit), 32'(want));
  endtask : seek

  initial begin
    logic [31:0] q, d;
    logic [9:0] ch;
    logic p;
    tk(10);
    rst <= 1'b0;
    dev_n <= 1'b1;
    tk(1);
    wb(1'b0, ADR_STATUS, 32'h0, q);
    chk(q & 32'hF0F, 32'h0);
    wb(1'b0, 8'h08, 32'h0, q);
    chk(q, 32'h0);
    d = rnd() & 32'hF03F;
    wb(1'b1, ADR_CTRL, d, q);
    wb(1'b0, ADR_CTRL, 32'h0, q);
    chk(q, d);
    $display("done: registers");
    latch(1'b1, 8'hB7);
    bus <= 8'h48;
    tk(3);
    chk(32'(den), 32'h7);
    latch(1'b1, 8'hFF);
    $display("done: enables");
    for (int k = 0; k < 4; k++) begin
      q = rnd();
      ch = q[9:0];
      p = (k == 0 || k == 3) ? ^ch : q[10];
      wb(1'b1, ADR_CTRL, {28'h0, k[1:0], 2'h0}, q);
      din <= {4{ch}};
      par <= {4{p}};
      seek(k, exp_char(ch, p, k[1:0]), 45, 1'b1);
    end
    $display("done: characters");
    wb(1'b1, ADR_CTRL, 32'h1000, q);
    latch(1'b1, 8'hFE);
    seek(2, 10'h3FF, 20, 1'b1);
    seek(0, 10'h000, 20, 1'b1);
    latch(1'b1, 8'hFF);
    wb(1'b1, ADR_CTRL, 32'h0, q);
    $display("done: loopback");
    latch(1'b0, 8'hFD);
    // closed latch must ignore the bus from here on
    bus <= 8'hFF;
    seek(0, bist_char(1), 40, 1'b1);
    // last host character has drained by now
    seek(0, ch, 40, 1'b0);
    seek(1, ch, 40, 1'b1);
    latch(1'b0, 8'hFF);
    $display("done: self-test");
    for (int s = 0; s < 2; s++) begin
      wb(1'b1, ADR_CTRL, (s == 0) ? 32'h3 : 32'h1, q);
      binit();
      seek(3, ch, 60, 1'b1);
      half = 2;
      tk(80);
      chk(32'(aerr), 32'hF);
      half = 5;
      seek(1, INVALID_CHAR, 20, 1'b1);
      wb(1'b0, ADR_STATUS, 32'h0, q);
      chk(q & 32'hF, 32'hF);
      binit();
      chk(32'(aerr), 32'h0);
    end
    $display("done: buffered");
    // half-rate reference needs a speed range above the lowest
    wb(1'b1, ADR_CTRL, 32'h130, q);
    binit();
    seek(3, ch, 60, 1'b1);
    wb(1'b0, ADR_STATUS, 32'h0, q);
    chk(q & 32'h100F, 32'h0);
    $display("done: half-rate");
    dev_n <= 1'b0;
    tk(2);
    dev_n <= 1'b1;
    tk(1);
    chk(32'(den), 32'h0);
    $display("done: device reset");
    report_and_stop();
  end
endmodule : tb_top

bind qst_tx_path qst_tx_path_assertions i_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .device_reset_n_i, .align_buffer_init_n_i, .driver_latch_open_i, .shared_enable_bus_i,
  .serial_out_o, .serial_drive_en_o, .align_error_out_o);
`default_nettype wire
